// ### core/rpa_params.svh
// register offsets, field positions, reset values for the rx port block
`ifndef RPA_PARAMS_SVH
`define RPA_PARAMS_SVH
`define RPA_ALIAS5_OFF 8'h6a
`define RPA_ALIAS6_OFF 8'h6b
`define RPA_ALIAS7_OFF 8'h6c
`define RPA_CONFIG_OFF 8'h6d
`define RPA_ALIAS_RST 8'h00
`define RPA_CONFIG_RST 8'h78
`define RPA_CFG_WAIT_FS1 7
`define RPA_CFG_WAIT_FS 6
`define RPA_CFG_PASS_SUM 5
`define RPA_CFG_PASS_ECC 4
`define RPA_CFG_LEN_LINE 3
`define RPA_CFG_RSVD 2
`define RPA_ALIAS_ACK 0
`define RPA_FIRST_FRAME 16'h0001
`define RPA_DATA_W 32
`define RPA_FIFO_DEPTH 4
`endif

// ### core/rpa_pkg.sv
// types shared by the rx port alias and input config block
package rpa_pkg;
  typedef enum logic [1:0] {
    RPA_CSI2,
    RPA_RAW12_LF,
    RPA_RAW12_HF,
    RPA_RAW10
  } rpa_mode_t;
  typedef logic [6:0] rpa_addr_t;
endpackage

// ### core/rpa_port_cfg.sv
// rx port alias decode, input configuration and packet filter with fifo
// Notes on behaviour
// - each alias register holds a 7-bit alias in bits 7:1 decoding local i2c
// - an alias hit swaps in the matching remote target id for the link
// - an alias of zero never matches, so that entry is disabled
// - bit 0 set makes the device acknowledge every write to that alias itself
// - bit 7 set drops csi-2 packets until frame start with count one
// - bit 6 set with bit 7 clear drops csi-2 packets until any frame start arrives
// - raw modes ignore frame start waits and checksum and ecc forwarding
// - bit 5 one forwards payload checksum errors, zero drops them
// - bit 4 one forwards header ecc errors, zero drops them
// - raw mode: bit 3 one drops short first line, zero forwards it
// - csi-2 mode: bit 3 one forwards length errors, zero drops them
// - mode field bits 1:0 loads from straps after reset and stays writable
// - registers are per port; host picks the copy by port select first
`include "rpa_params.svh"

// ----------------------------------------------------------------
// shift fifo, head word held in flip-flops
// ----------------------------------------------------------------
module rpa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int CW = $clog2(DEPTH) + 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic rdy_reg;
  logic vld_reg;
  wire push = in_valid & rdy_reg;
  wire pop = vld_reg & out_ready;

  // occupancy after this cycle
  assign cnt_next = cnt_reg + CW'(push) - CW'(pop);
  assign in_ready = rdy_reg;
  assign out_valid = vld_reg;
  assign out_data = mem_reg[0];

  // flags kept in flops so the ports come straight from registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      rdy_reg <= 1'b0;
      vld_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      rdy_reg <= cnt_next != CW'(DEPTH);
      vld_reg <= cnt_next != '0;
    end
  end

  // entries shift toward the head on a pop
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (pop) begin
        if (push && CW'(i + 1) == cnt_reg) begin
          mem_reg[i] <= in_data;
        end else if (i < DEPTH - 1) begin
          mem_reg[i] <= mem_reg[(i + 1) % DEPTH]; // index kept in range
        end
      end else if (push && CW'(i) == cnt_reg) begin
        mem_reg[i] <= in_data;
      end
    end
  end

  fifo_full_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt_reg == CW'(DEPTH) |-> !rdy_reg) else $error("fifo full yet ready");
  fifo_room_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) && cnt_reg != CW'(DEPTH) |-> rdy_reg)
    else $error("fifo has room yet not ready");
  fifo_valid_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    vld_reg == (cnt_reg != CW'(0)))
    else $error("fifo valid flag off by one");
endmodule

// ----------------------------------------------------------------
// top: one receive port's copy of the registers
// ----------------------------------------------------------------
module rpa_port_cfg #(
  parameter logic [1:0] RX_PORT = 2'h0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] port_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] mode_strap,
  output logic [1:0] link_input_mode,
  input wire logic i2c_req,
  input wire logic i2c_write,
  input wire rpa_pkg::rpa_addr_t i2c_addr,
  input wire rpa_pkg::rpa_addr_t remote_id_5,
  input wire rpa_pkg::rpa_addr_t remote_id_6,
  input wire rpa_pkg::rpa_addr_t remote_id_7,
  output logic fwd_hit,
  output rpa_pkg::rpa_addr_t fwd_addr,
  output logic auto_ack,
  input wire logic pkt_valid,
  output logic pkt_ready,
  input wire logic [`RPA_DATA_W-1:0] pkt_data,
  input wire logic pkt_fs,
  input wire logic [15:0] pkt_frame_num,
  input wire logic pkt_sum_err,
  input wire logic pkt_ecc_err,
  input wire logic pkt_len_err,
  input wire logic pkt_short_line,
  output logic out_valid,
  input wire logic out_ready,
  output logic [`RPA_DATA_W-1:0] out_data
);
  logic [7:0] alias_reg [3];
  logic [7:0] cfg_reg;
  logic [7:0] rdata_reg;
  logic strap_pend_reg;
  logic fs_seen_reg;
  logic fs1_seen_reg;
  logic hit_reg;
  rpa_pkg::rpa_addr_t fwd_addr_reg;
  logic ack_reg;

  // 0..2 for alias 5..7, 3 for none
  function automatic logic [1:0] alias_index(input logic [7:0] off);
    logic [1:0] idx;
    idx = 2'h3;
    if (off == `RPA_ALIAS5_OFF) idx = 2'h0;
    if (off == `RPA_ALIAS6_OFF) idx = 2'h1;
    if (off == `RPA_ALIAS7_OFF) idx = 2'h2;
    return idx;
  endfunction

  // an entry matches only when its alias is nonzero
  function automatic logic alias_match(input logic [7:0] ent,
                                       input rpa_pkg::rpa_addr_t a);
    return ent[7:1] != 7'h00 && ent[7:1] == a;
  endfunction

  // ----------------------------------------------------------------
  // register access through the port select
  // ----------------------------------------------------------------
  wire port_on = port_sel == RX_PORT;
  wire wr_en = reg_wr & port_on;
  wire [1:0] wr_idx = alias_index(reg_addr);
  wire [1:0] rd_idx = alias_index(reg_addr);
  wire cfg_wr = wr_en && reg_addr == `RPA_CONFIG_OFF;
  wire [7:0] cfg_wmask = 8'hfb;
  wire [7:0] rd_mux = !port_on ? 8'h00 :
                      rd_idx != 2'h3 ? alias_reg[rd_idx] :
                      reg_addr == `RPA_CONFIG_OFF ? cfg_reg : 8'h00;

  // alias entries
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (!rst_n) begin
        alias_reg[i] <= `RPA_ALIAS_RST;
      end else if (wr_en && wr_idx == 2'(i)) begin
        alias_reg[i] <= reg_wdata;
      end
    end
  end

  // config, mode field taken from straps the cycle after release
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_reg <= `RPA_CONFIG_RST;
      strap_pend_reg <= 1'b1;
    end else begin
      strap_pend_reg <= 1'b0;
      if (cfg_wr) begin
        cfg_reg <= reg_wdata & cfg_wmask;
      end else if (strap_pend_reg) begin
        cfg_reg[1:0] <= mode_strap;
      end
    end
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  assign reg_rdata = rdata_reg;
  assign link_input_mode = cfg_reg[1:0];

  // ----------------------------------------------------------------
  // i2c alias decode, lowest entry wins on duplicates
  // ----------------------------------------------------------------
  wire m5 = alias_match(alias_reg[0], i2c_addr);
  wire m6 = alias_match(alias_reg[1], i2c_addr);
  wire m7 = alias_match(alias_reg[2], i2c_addr);
  wire any_m = m5 | m6 | m7;
  wire [1:0] m_idx = m5 ? 2'h0 : m6 ? 2'h1 : 2'h2;
  wire rpa_pkg::rpa_addr_t remap = m5 ? remote_id_5 :
                                   m6 ? remote_id_6 : remote_id_7;
  wire ack_sel = alias_reg[m_idx][`RPA_ALIAS_ACK];

  // lookup result registered per request
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hit_reg <= 1'b0;
      fwd_addr_reg <= 7'h00;
      ack_reg <= 1'b0;
    end else begin
      hit_reg <= i2c_req & any_m;
      fwd_addr_reg <= (i2c_req & any_m) ? remap : 7'h00;
      ack_reg <= i2c_req & any_m & i2c_write & ack_sel;
    end
  end

  assign fwd_hit = hit_reg;
  assign fwd_addr = fwd_addr_reg;
  assign auto_ack = ack_reg;

  // ----------------------------------------------------------------
  // packet filter in front of the fifo
  // ----------------------------------------------------------------
  wire is_csi = cfg_reg[1:0] == 2'(rpa_pkg::RPA_CSI2);
  wire take = pkt_valid & pkt_ready;
  wire fs1_pkt = pkt_fs && pkt_frame_num == `RPA_FIRST_FRAME;
  wire fs1_open = fs1_seen_reg | fs1_pkt;
  wire fs_open = fs_seen_reg | pkt_fs;
  wire gate_ok = cfg_reg[`RPA_CFG_WAIT_FS1] ? fs1_open :
                 cfg_reg[`RPA_CFG_WAIT_FS] ? fs_open : 1'b1;
  wire err_drop = (pkt_sum_err & ~cfg_reg[`RPA_CFG_PASS_SUM]) |
                  (pkt_ecc_err & ~cfg_reg[`RPA_CFG_PASS_ECC]) |
                  (pkt_len_err & ~cfg_reg[`RPA_CFG_LEN_LINE]);
  wire raw_drop = pkt_short_line & cfg_reg[`RPA_CFG_LEN_LINE];
  wire keep = is_csi ? (gate_ok & ~err_drop) : ~raw_drop;
  wire push = pkt_valid & keep;

  // frame start trackers re-arm when the config is rewritten,
  // but a frame start taken in that same cycle still counts
  wire seen_now = take & is_csi;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fs_seen_reg <= 1'b0;
      fs1_seen_reg <= 1'b0;
    end else if (cfg_wr) begin
      fs_seen_reg <= seen_now & pkt_fs;
      fs1_seen_reg <= seen_now & fs1_pkt;
    end else if (seen_now) begin
      fs_seen_reg <= fs_open;
      fs1_seen_reg <= fs1_open;
    end
  end

  // dropped words are consumed but never queued
  rpa_fifo #(
    .WIDTH(`RPA_DATA_W),
    .DEPTH(`RPA_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(pkt_ready),
    .in_data(pkt_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  alias_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    i2c_req && alias_reg[0][7:1] != 7'h00 && i2c_addr == alias_reg[0][7:1]
    |=> fwd_hit) else $error("alias 5 match not reported");
  alias_remap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    i2c_req && m5 |=> fwd_addr == $past(remote_id_5))
    else $error("alias 5 not remapped");
  alias_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    i2c_req && i2c_addr == 7'h00 |=> !fwd_hit)
    else $error("zero alias matched");
  auto_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    i2c_req && i2c_write && m5 && alias_reg[0][0] |=> auto_ack)
    else $error("auto ack missing");
  wait_one_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_csi && cfg_reg[7] && !fs1_seen_reg && !fs1_pkt |-> !push)
    else $error("packet passed before frame one");
  wait_any_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_csi && !cfg_reg[7] && cfg_reg[6] && take && pkt_fs && !err_drop
    |-> push ##1 fs_seen_reg)
    else $error("frame start not opening gate");
  raw_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !is_csi && pkt_valid && !pkt_short_line |-> push)
    else $error("raw word dropped");
  sum_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_csi && pkt_sum_err && !cfg_reg[5] |-> !push)
    else $error("checksum error forwarded");
  ecc_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_csi && pkt_ecc_err && !cfg_reg[4] |-> !push)
    else $error("ecc error forwarded");
  short_line_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !is_csi && pkt_short_line && cfg_reg[3] |-> !push)
    else $error("short line forwarded");
  len_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_csi && pkt_len_err && !cfg_reg[3] |-> !push)
    else $error("length error forwarded");
  strap_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    strap_pend_reg && !cfg_wr |=> link_input_mode == $past(mode_strap))
    else $error("strap not loaded");
  port_guard_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && port_sel != RX_PORT |=> $stable(alias_reg[0]) &&
    $stable(alias_reg[1]) && $stable(alias_reg[2]))
    else $error("write hit other port copy");
  rsvd_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd ##1 1'b1 |-> !reg_rdata[2] && !cfg_reg[2])
    else $error("reserved bit set");
  alias_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && wr_idx == 2'h0 |=> alias_reg[0] == $past(reg_wdata))
    else $error("alias 5 write lost");
  no_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    i2c_req && !any_m |=> !fwd_hit && !auto_ack)
    else $error("lookup without match reported");
  read_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    i2c_req && !i2c_write |=> !auto_ack)
    else $error("auto ack on a read");
  short_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !is_csi && pkt_valid && !cfg_reg[3] |-> push)
    else $error("raw word dropped with discard off");
  cfg_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_wr |=> link_input_mode == $past(reg_wdata[1:0]))
    else $error("mode field not writable");
  read_port_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && !port_on |=> reg_rdata == 8'h00)
    else $error("other port copy read back");
endmodule

// ### sim/rpa_sink.sv
// drain-side model that takes words from the block's output fifo
module rpa_sink (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic out_valid,
  input wire logic [31:0] out_data,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_got = 0;
  logic [31:0] last = 32'h0;
  // ----------------------------------------------------------------
  // take a word on every edge with valid and ready
  // ----------------------------------------------------------------
  assign out_ready = !stall;  // stalls when asked, never early
  always @(posedge ref_clk) begin
    if (rst_n && out_valid && out_ready) begin
      n_got <= n_got + 1;
      last <= out_data;
    end
  end
endmodule

// ### sim/rx_port_alias_and_input_config_test.sv
// self-checking bench for one rx port copy of the alias and config block
module rx_port_alias_and_input_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic i2c_req = 1'h0;
  logic i2c_write = 1'h0;
  logic pkt_valid = 1'h0;
  logic pkt_fs = 1'h0;
  logic stall = 1'h0;
  logic [1:0] port_sel = 2'h1;
  logic [1:0] mode_strap = 2'h2;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  rpa_pkg::rpa_addr_t i2c_addr = 7'h00;
  logic [15:0] pkt_frame_num = 16'h0000;
  logic [3:0] perr = 4'h0;  // sum, ecc, length, short line
  logic [31:0] pkt_data = 32'h0;
  logic [31:0] exp_last = 32'h0;
  logic [7:0] reg_rdata;
  logic [1:0] link_input_mode;
  rpa_pkg::rpa_addr_t fwd_addr;
  logic [31:0] out_data;
  logic fwd_hit, auto_ack, pkt_ready, out_valid, out_ready;
  int fails = 0;
  int n_checks = 0;
  int n_exp = 0;
  // ----------------------------------------------------------------
  // clock, design and drain model
  // ----------------------------------------------------------------
  initial forever #4 ref_clk = ~ref_clk;
  rpa_port_cfg #(.RX_PORT(2'h1)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .port_sel(port_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mode_strap(mode_strap), .link_input_mode(link_input_mode),
    .i2c_req(i2c_req), .i2c_write(i2c_write), .i2c_addr(i2c_addr),
    .remote_id_5(7'h51), .remote_id_6(7'h52), .remote_id_7(7'h53),
    .fwd_hit(fwd_hit), .fwd_addr(fwd_addr), .auto_ack(auto_ack),
    .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_data(pkt_data),
    .pkt_fs(pkt_fs), .pkt_frame_num(pkt_frame_num),
    .pkt_sum_err(perr[3]), .pkt_ecc_err(perr[2]), .pkt_len_err(perr[1]),
    .pkt_short_line(perr[0]), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));
  rpa_sink sink (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
  // ----------------------------------------------------------------
  // compare, verdict and access tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task give_verdict;
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_rd = 1'h1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'h0;
    chk("reg_rdata", {24'h0, e}, {24'h0, reg_rdata});
  endtask
  // one address lookup, answer checked in the cycle it stands
  task look(input rpa_pkg::rpa_addr_t a, input logic w, input logic h,
            input rpa_pkg::rpa_addr_t fa, input logic ak);
    @(negedge ref_clk);
    i2c_req = 1'h1;
    i2c_addr = a;
    i2c_write = w;
    @(negedge ref_clk);
    i2c_req = 1'h0;
    chk("fwd_hit", {31'h0, h}, {31'h0, fwd_hit});
    chk("fwd_addr", {25'h0, fa}, {25'h0, fwd_addr});
    chk("auto_ack", {31'h0, ak}, {31'h0, auto_ack});
  endtask
  // one word offered once room is shown; kept says it must come out
  task pk(input logic fs, input logic [15:0] fn, input logic [3:0] er,
          input logic kept);
    int k;
    k = 0;
    @(negedge ref_clk);
    while (pkt_ready !== 1'h1 && k < 50) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 50) fails++;
    pkt_valid = 1'h1;
    pkt_fs = fs;
    pkt_frame_num = fn;
    perr = er;
    pkt_data = pkt_data + 32'h1;
    if (kept) begin
      n_exp++;
      exp_last = pkt_data;
    end
    @(negedge ref_clk);
    pkt_valid = 1'h0;
  endtask
  task outc;
    repeat (8) @(negedge ref_clk);
    chk("words out", n_exp, sink.n_got);
    chk("last word", exp_last, sink.last);
  endtask
  // ----------------------------------------------------------------
  // test sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #200000;
    fails++;
    give_verdict;
  end
  initial begin
    repeat (3) @(negedge ref_clk);
    rst_n = 1'h1;
    @(negedge ref_clk);
    chk("mode", 32'h2, {30'h0, link_input_mode});
    rd(8'h6a, 8'h00);
    rd(8'h6b, 8'h00);
    rd(8'h6c, 8'h00);
    rd(8'h6d, 8'h7a);
    wr(8'h6d, 8'hff);
    rd(8'h6d, 8'hfb);
    chk("mode", 32'h3, {30'h0, link_input_mode});
    rd(8'h6e, 8'h00);
    port_sel = 2'h2;
    wr(8'h6a, 8'hff);
    rd(8'h6a, 8'h00);
    port_sel = 2'h1;
    rd(8'h6a, 8'h00);
    wr(8'h6a, 8'h43);
    wr(8'h6b, 8'h44);
    wr(8'h6c, 8'h47);
    look(7'h21, 1'h1, 1'h1, 7'h51, 1'h1);
    look(7'h21, 1'h0, 1'h1, 7'h51, 1'h0);
    look(7'h22, 1'h1, 1'h1, 7'h52, 1'h0);
    look(7'h23, 1'h1, 1'h1, 7'h53, 1'h1);
    wr(8'h6b, 8'h42);
    look(7'h21, 1'h1, 1'h1, 7'h51, 1'h1);
    wr(8'h6c, 8'h00);
    look(7'h23, 1'h1, 1'h0, 7'h00, 1'h0);
    look(7'h00, 1'h1, 1'h0, 7'h00, 1'h0);
    wr(8'h6d, 8'h78);
    pk(1'h0, 16'h0, 4'h0, 1'h0);
    pk(1'h1, 16'h5, 4'h0, 1'h1);
    pk(1'h0, 16'h0, 4'h0, 1'h1);
    outc;
    wr(8'h6d, 8'h40);
    pk(1'h1, 16'h3, 4'h0, 1'h1);
    pk(1'h0, 16'h0, 4'h8, 1'h0);
    pk(1'h0, 16'h0, 4'h4, 1'h0);
    pk(1'h0, 16'h0, 4'h2, 1'h0);
    pk(1'h0, 16'h0, 4'h0, 1'h1);
    outc;
    wr(8'h6d, 8'h78);
    pk(1'h1, 16'h3, 4'h0, 1'h1);
    pk(1'h0, 16'h0, 4'h8, 1'h1);
    pk(1'h0, 16'h0, 4'h4, 1'h1);
    pk(1'h0, 16'h0, 4'h2, 1'h1);
    outc;
    wr(8'h6d, 8'hb8);
    pk(1'h1, 16'h2, 4'h0, 1'h0);
    pk(1'h0, 16'h0, 4'h0, 1'h0);
    pk(1'h1, 16'h1, 4'h0, 1'h1);
    pk(1'h0, 16'h0, 4'h0, 1'h1);
    outc;
    wr(8'h6d, 8'hc9);
    chk("mode", 32'h1, {30'h0, link_input_mode});
    pk(1'h0, 16'h0, 4'h8, 1'h1);
    pk(1'h0, 16'h0, 4'h1, 1'h0);
    outc;
    wr(8'h6d, 8'hc1);
    pk(1'h0, 16'h0, 4'h1, 1'h1);
    outc;
    stall = 1'h1;
    repeat (4) pk(1'h0, 16'h0, 4'h0, 1'h1);
    chk("pkt_ready", 32'h0, {31'h0, pkt_ready});
    stall = 1'h0;
    outc;
    mode_strap = 2'h1;
    rst_n = 1'h0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'h1;
    @(negedge ref_clk);
    chk("mode", 32'h1, {30'h0, link_input_mode});
    rd(8'h6d, 8'h79);
    rd(8'h6a, 8'h00);
    give_verdict;
  end
endmodule
